// ===== rtl/asm_pkg.sv
// Purpose: shared constants and types for the asynchronous serial port, ten-bit frame mode
// Assumes: one 100 MHz system clock; timer 1 overflow arrives as a one-cycle tick on that clock
// Notes: register offsets are word indices on the plain register port
//
// Overview of operation
// - frame: start zero, eight data lsb first, stop one
// - transmit and receive run independently, full duplex
// - received stop bit stored in received extra bit
// - bit rate is overflow over 16 or 32
// - buffer register write starts one frame
// - first bit after first divide-by-16 rollover
// - later bits follow each later rollover
// - stop bit follows the eighth data bit
// - done flag set at tenth rollover after write
// - receiver idle unless receive enable set
// - reception starts on input falling edge
// - edge detector samples at sixteen times bit rate
// - start edge resets divide-by-16 counter at once
package asm_pkg;
   // ------------------------------------------------------------
   // register map
   // ------------------------------------------------------------
   localparam logic [1:0] ASM_ADDR_BUFFER = 2'h0;
   localparam logic [1:0] ASM_ADDR_CONTROL = 2'h1;
   // control register field positions
   localparam int ASM_CTL_TX_DONE = 0;
   localparam int ASM_CTL_RX_DONE = 1;
   localparam int ASM_CTL_EXTRA = 2;
   localparam int ASM_CTL_RX_EN = 4;
   localparam int ASM_CTL_DIV32 = 5;
   localparam int ASM_CTL_TX_BUSY = 6;
   localparam int ASM_CTL_RX_BUSY = 7;
   localparam logic [7:0] ASM_CTL_RESET = 8'h00;
   localparam logic [7:0] ASM_BUF_RESET = 8'h00;
   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int ASM_DIV_BITS = 4;
   localparam logic [3:0] ASM_MID_SAMPLE = 4'h7;
   localparam logic [3:0] ASM_FRAME_BITS = 4'hA;
   localparam logic [3:0] ASM_DATA_BITS = 4'h8;
   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef struct packed {
      logic [1:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } asm_bus_req_t;
   typedef enum logic [1:0] {
      ASM_RX_IDLE = 2'b00,
      ASM_RX_START = 2'b01,
      ASM_RX_DATA = 2'b11,
      ASM_RX_STOP = 2'b10
   } asm_rx_state_t;
endpackage : asm_pkg

// ===== rtl/asm_tick_gen.sv
// Purpose: sixteen-times bit-rate tick from the timer 1 overflow
// Assumes: overflow is a one-cycle pulse in the system clock domain
// Notes: halving for the slow rate is a toggle, so ticks stay one cycle wide
`timescale 1ns/1ps
module asm_tick_gen (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // control
   input wire logic timer_ovf,
   input wire logic div32,
   // tick out
   output logic tick_x16
);
   import asm_pkg::*;
   logic half_reg;
   logic half_next;
   logic tick_reg;
   logic tick_next;

   always_comb begin
      half_next = half_reg;
      tick_next = 1'b0;
      if (timer_ovf) begin
         half_next = ~half_reg;
         tick_next = div32 ? half_reg : 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         half_reg <= 1'b0;
         tick_reg <= 1'b0;
      end else begin
         half_reg <= half_next;
         tick_reg <= tick_next;
      end
   end

   assign tick_x16 = tick_reg;
endmodule : asm_tick_gen

// ===== rtl/asm_serial_port.sv
// Purpose: full-duplex asynchronous serial port, ten-bit frames
// Assumes: serial input is asynchronous and passes two flip-flops first
// Notes: transmit and receive each keep their own divide-by-16 counter
//
// Implementation choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
module asm_serial_port (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // register port
   input wire asm_pkg::asm_bus_req_t bus_req,
   output logic [7:0] rdata,
   // timer 1 overflow tick
   input wire logic timer_ovf,
   // serial pins
   input wire logic rxd,
   output logic txd
);
   import asm_pkg::*;

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   logic tick;
   logic [1:0] rx_sync_reg;
   logic [7:0] rdata_reg, rdata_next;
   logic tx_done_reg, tx_done_next;
   logic rx_done_reg, rx_done_next;
   logic extra_reg, extra_next;
   logic rx_en_reg, rx_en_next;
   logic div32_reg, div32_next;
   logic [7:0] rx_buf_reg, rx_buf_next;
   // transmit
   logic [3:0] tx_div_reg, tx_div_next;
   logic tx_pend_reg, tx_pend_next;
   logic tx_busy_reg, tx_busy_next;
   logic [3:0] tx_cnt_reg, tx_cnt_next;
   logic [8:0] tx_sh_reg, tx_sh_next;
   logic txd_reg, txd_next;
   // receive
   asm_rx_state_t rx_st_reg, rx_st_next;
   logic [3:0] rx_div_reg, rx_div_next;
   logic [3:0] rx_cnt_reg, rx_cnt_next;
   logic [7:0] rx_sh_reg, rx_sh_next;
   logic rx_prev_reg, rx_prev_next;

   logic wr_buf, wr_ctl, rd_ctl;
   logic rx_in;
   logic [7:0] ctl_view;

   function automatic logic [3:0] inc4(input logic [3:0] v);
      inc4 = v + 4'h1;
   endfunction : inc4

   asm_tick_gen u_tick (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .timer_ovf(timer_ovf),
      .div32(div32_reg),
      .tick_x16(tick)
   );

   // ------------------------------------------------------------
   // input synchroniser
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_sync_reg <= 2'h3;
      end else begin
         rx_sync_reg <= {rx_sync_reg[0], rxd};
      end
   end
   assign rx_in = rx_sync_reg[1];

   // ------------------------------------------------------------
   // register access
   // ------------------------------------------------------------
   assign wr_buf = bus_req.wr && (bus_req.addr == ASM_ADDR_BUFFER);
   assign wr_ctl = bus_req.wr && (bus_req.addr == ASM_ADDR_CONTROL);
   assign rd_ctl = bus_req.rd && (bus_req.addr == ASM_ADDR_CONTROL);

   always_comb begin
      ctl_view = 8'h00;
      ctl_view[ASM_CTL_TX_DONE] = tx_done_reg;
      ctl_view[ASM_CTL_RX_DONE] = rx_done_reg;
      ctl_view[ASM_CTL_EXTRA] = extra_reg;
      ctl_view[ASM_CTL_RX_EN] = rx_en_reg;
      ctl_view[ASM_CTL_DIV32] = div32_reg;
      ctl_view[ASM_CTL_TX_BUSY] = tx_busy_reg | tx_pend_reg;
      ctl_view[ASM_CTL_RX_BUSY] = (rx_st_reg != ASM_RX_IDLE);
   end

   always_comb begin
      rdata_next = 8'h00;
      if (bus_req.rd && bus_req.addr == ASM_ADDR_BUFFER) begin
         rdata_next = rx_buf_reg;
      end else if (rd_ctl) begin
         rdata_next = ctl_view;
      end
   end

   // ------------------------------------------------------------
   // transmitter
   // ------------------------------------------------------------
   always_comb begin
      tx_div_next = tick ? inc4(tx_div_reg) : tx_div_reg;
      tx_pend_next = tx_pend_reg;
      tx_busy_next = tx_busy_reg;
      tx_cnt_next = tx_cnt_reg;
      tx_sh_next = tx_sh_reg;
      txd_next = txd_reg;
      tx_done_next = tx_done_reg;
      if (wr_ctl && !bus_req.wdata[ASM_CTL_TX_DONE]) begin
         tx_done_next = 1'b0;
      end
      if (wr_buf) begin
         tx_pend_next = 1'b1;
         tx_busy_next = 1'b0;
         tx_sh_next = {1'b1, bus_req.wdata};
         tx_cnt_next = 4'h0;
      end else if (tick && tx_div_reg == 4'hF) begin
         // rollover of the free-running counter paces every bit
         if (tx_pend_reg) begin
            tx_pend_next = 1'b0;
            tx_busy_next = 1'b1;
            txd_next = 1'b0;
            tx_cnt_next = 4'h1;
         end else if (tx_busy_reg) begin
            if (tx_cnt_reg == ASM_FRAME_BITS - 4'h1) begin
               // the stop bit goes out on the same rollover that raises the flag
               txd_next = tx_sh_reg[0];
               tx_busy_next = 1'b0;
               tx_done_next = 1'b1;
            end else begin
               txd_next = tx_sh_reg[0];
               tx_sh_next = {1'b1, tx_sh_reg[8:1]};
               tx_cnt_next = inc4(tx_cnt_reg);
            end
         end
      end
   end

   // ------------------------------------------------------------
   // receiver
   // ------------------------------------------------------------
   always_comb begin
      rx_st_next = rx_st_reg;
      rx_div_next = rx_div_reg;
      rx_cnt_next = rx_cnt_reg;
      rx_sh_next = rx_sh_reg;
      rx_buf_next = rx_buf_reg;
      rx_done_next = rx_done_reg;
      extra_next = extra_reg;
      rx_prev_next = rx_prev_reg;
      rx_en_next = rx_en_reg;
      div32_next = div32_reg;
      if (wr_ctl) begin
         rx_en_next = bus_req.wdata[ASM_CTL_RX_EN];
         div32_next = bus_req.wdata[ASM_CTL_DIV32];
         if (!bus_req.wdata[ASM_CTL_RX_DONE]) begin
            rx_done_next = 1'b0;
         end
      end
      if (tick) begin
         rx_prev_next = rx_in;
         rx_div_next = inc4(rx_div_reg);
      end
      if (!rx_en_reg) begin
         rx_st_next = ASM_RX_IDLE;
      end else if (tick) begin
         unique case (rx_st_reg)
            ASM_RX_IDLE: begin
               if (rx_prev_reg && !rx_in) begin
                  rx_div_next = 4'h0;
                  rx_st_next = ASM_RX_START;
               end
            end
            ASM_RX_START: begin
               if (rx_div_reg == ASM_MID_SAMPLE) begin
                  // a glitch that is high again mid bit is not a start
                  rx_st_next = rx_in ? ASM_RX_IDLE : ASM_RX_DATA;
                  rx_cnt_next = 4'h0;
               end
            end
            ASM_RX_DATA: begin
               if (rx_div_reg == ASM_MID_SAMPLE) begin
                  rx_sh_next = {rx_in, rx_sh_reg[7:1]};
                  rx_cnt_next = inc4(rx_cnt_reg);
                  if (rx_cnt_reg == ASM_DATA_BITS - 4'h1) begin
                     rx_st_next = ASM_RX_STOP;
                  end
               end
            end
            ASM_RX_STOP: begin
               if (rx_div_reg == ASM_MID_SAMPLE) begin
                  rx_buf_next = rx_sh_reg;
                  extra_next = rx_in;
                  rx_done_next = 1'b1;
                  rx_st_next = ASM_RX_IDLE;
               end
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_reg <= ASM_BUF_RESET;
         tx_done_reg <= 1'b0;
         rx_done_reg <= 1'b0;
         extra_reg <= 1'b0;
         rx_en_reg <= ASM_CTL_RESET[ASM_CTL_RX_EN];
         div32_reg <= ASM_CTL_RESET[ASM_CTL_DIV32];
         rx_buf_reg <= ASM_BUF_RESET;
         tx_div_reg <= 4'h0;
         tx_pend_reg <= 1'b0;
         tx_busy_reg <= 1'b0;
         tx_cnt_reg <= 4'h0;
         tx_sh_reg <= 9'h1FF;
         txd_reg <= 1'b1;
         rx_st_reg <= ASM_RX_IDLE;
         rx_div_reg <= 4'h0;
         rx_cnt_reg <= 4'h0;
         rx_sh_reg <= 8'h00;
         rx_prev_reg <= 1'b1;
      end else begin
         rdata_reg <= rdata_next;
         tx_done_reg <= tx_done_next;
         rx_done_reg <= rx_done_next;
         extra_reg <= extra_next;
         rx_en_reg <= rx_en_next;
         div32_reg <= div32_next;
         rx_buf_reg <= rx_buf_next;
         tx_div_reg <= tx_div_next;
         tx_pend_reg <= tx_pend_next;
         tx_busy_reg <= tx_busy_next;
         tx_cnt_reg <= tx_cnt_next;
         tx_sh_reg <= tx_sh_next;
         txd_reg <= txd_next;
         rx_st_reg <= rx_st_next;
         rx_div_reg <= rx_div_next;
         rx_cnt_reg <= rx_cnt_next;
         rx_sh_reg <= rx_sh_next;
         rx_prev_reg <= rx_prev_next;
      end
   end

   assign rdata = rdata_reg;
   assign txd = txd_reg;
endmodule : asm_serial_port

// ===== tb/asm_serial_port_sva.sv
// Purpose: port checks for the serial port
// Assumes: timer_ovf pulses every fourth cycle
// Notes: shadows follow control writes
`timescale 1ns/1ps
module asm_serial_port_sva (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // watched ports
   input wire asm_pkg::asm_bus_req_t bus_req,
   input wire logic [7:0] rdata,
   input wire logic timer_ovf,
   input wire logic rxd,
   input wire logic txd
);
   import asm_pkg::*;
   logic en_reg, en_next, div_reg, div_next;
   always_comb begin
      en_next = en_reg;
      div_next = div_reg;
      if (bus_req.wr && bus_req.addr == ASM_ADDR_CONTROL) begin
         en_next = bus_req.wdata[ASM_CTL_RX_EN];
         div_next = bus_req.wdata[ASM_CTL_DIV32];
      end
   end
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         en_reg <= ASM_CTL_RESET[ASM_CTL_RX_EN];
         div_reg <= ASM_CTL_RESET[ASM_CTL_DIV32];
      end else begin
         en_reg <= en_next;
         div_reg <= div_next;
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   a_reset_idle: assert property ($rose(rst_n) |-> txd)
      else $error("txd low after reset");
   a_rdata_idle: assert property (!$past(bus_req.rd) |-> rdata == 8'h00)
      else $error("rdata not zero");
   a_unmapped_zero: assert property (bus_req.rd && bus_req.addr[1] |=> rdata == 8'h00)
      else $error("unmapped read not zero");
   // bits are locked to the tick, never to the write itself
   a_txd_on_tick: assert property ($changed(txd) |-> $past(timer_ovf, 1) || $past(timer_ovf, 2) ||
      $past(timer_ovf, 3)) else $error("txd moved off tick");
   a_bit_hold: assert property ($changed(txd) |=> $stable(txd) [*8])
      else $error("txd bit too short");
   a_tx_busy_now: assert property (bus_req.wr && bus_req.addr == ASM_ADDR_BUFFER ##1
      bus_req.rd && bus_req.addr == ASM_ADDR_CONTROL |=> rdata[ASM_CTL_TX_BUSY])
      else $error("no busy after write");
   a_rx_off_idle: assert property (!en_reg && bus_req.rd && bus_req.addr == ASM_ADDR_CONTROL
      |=> !rdata[ASM_CTL_RX_BUSY]) else $error("rx busy while disabled");
   a_ctl_readback: assert property (bus_req.rd && bus_req.addr == ASM_ADDR_CONTROL |=>
      rdata[ASM_CTL_RX_EN] == en_reg && rdata[ASM_CTL_DIV32] == div_reg) else $error("control readback");
endmodule : asm_serial_port_sva
bind asm_serial_port asm_serial_port_sva u_sva (.sys_clk(sys_clk), .rst_n(rst_n), .bus_req(bus_req),
   .rdata(rdata), .timer_ovf(timer_ovf), .rxd(rxd), .txd(txd));

// ===== tb/asm_remote_node.sv
// Purpose: remote serial node facing the port
// Assumes: bit_cyc is the bit time in clocks
// Notes: one frame at a time each way
`timescale 1ns/1ps
module asm_remote_node (
   // clock and pacing
   input wire logic sys_clk,
   input wire logic [7:0] bit_cyc,
   // frame to send
   input wire logic send,
   input wire logic [7:0] send_byte,
   // serial lines
   input wire logic txd,
   output logic rxd,
   // frame heard
   output logic got,
   output logic [9:0] got_frame
);
   initial begin
      rxd = 1'h1;
      got = 1'h0;
      got_frame = 10'h000;
   end
   always @(posedge sys_clk) begin : tx_side
      logic [9:0] f;
      f = {1'h1, send_byte, 1'h0};
      if (send) begin
         for (int i = 0; i < 10; i++) begin
            rxd <= f[i];
            repeat (bit_cyc) @(posedge sys_clk);
         end
      end
   end
   // sampling mid bit keeps us clear of the port's tick jitter
   always @(negedge txd) begin : rx_side
      logic [9:0] f;
      repeat (bit_cyc / 2) @(posedge sys_clk);
      for (int i = 0; i < 10; i++) begin
         f[i] = txd;
         if (i < 9) repeat (bit_cyc) @(posedge sys_clk);
      end
      got_frame <= f;
      got <= 1'h1;
      @(posedge sys_clk);
      got <= 1'h0;
   end
endmodule : asm_remote_node

// ===== tb/async_serial_mode_one_tb_top.sv
// Purpose: self-checking bench for the serial port
// Assumes: overflow every 4 clocks, so a bit is 64 or 128 clocks
// Notes: read results are matched in order by the monitor
`timescale 1ns/1ps
module async_serial_mode_one_tb_top;
   import asm_pkg::*;
   logic sys_clk = 1'h0, rst_n = 1'h0, timer_ovf = 1'h0, send = 1'h0, rd_seen = 1'h0;
   asm_bus_req_t bus_req = '0;
   logic rxd, txd, got;
   logic [9:0] got_frame;
   logic [7:0] rdata, last_rd, b, bit_cyc = 8'h40, send_byte = 8'h00;
   logic [15:0] exp_rd[$];
   logic [9:0] exp_tx[$];
   int n_fail = 0, num_checks = 0, cyc = 0, t0, bc;
   asm_serial_port uut (.sys_clk(sys_clk), .rst_n(rst_n), .bus_req(bus_req), .rdata(rdata),
      .timer_ovf(timer_ovf), .rxd(rxd), .txd(txd));
   asm_remote_node peer (.sys_clk(sys_clk), .bit_cyc(bit_cyc), .send(send), .send_byte(send_byte),
      .txd(txd), .rxd(rxd), .got(got), .got_frame(got_frame));
   task automatic wrap_up();
      $display("checks %0d, mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : wrap_up
   task automatic chk(input logic ok, input string what);
      num_checks++;
      if (ok !== 1'h1) begin
         n_fail++;
         $display("[ERR] %0t %s", $time, what);
      end
   endtask : chk
   task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      bus_req.addr <= a;
      bus_req.wdata <= d;
      bus_req.wr <= 1'h1;
      @(posedge sys_clk);
      bus_req.wr <= 1'h0;
   endtask : wr_reg
   // upper byte of a note is the mask; a zero mask marks a poll
   task automatic rd_reg(input logic [1:0] a, input logic [15:0] em);
      @(posedge sys_clk);
      bus_req.addr <= a;
      bus_req.rd <= 1'h1;
      exp_rd.push_back(em);
      @(posedge sys_clk);
      bus_req.rd <= 1'h0;
   endtask : rd_reg
   task automatic wait_flag(input int f, output int t);
      t = cyc;
      repeat (500) begin
         rd_reg(ASM_ADDR_CONTROL, 16'h0000);
         @(posedge sys_clk);
         #1;
         if (last_rd[f] === 1'h1) break;
      end
      t = cyc - t;
      chk(last_rd[f] === 1'h1, "flag never set");
   endtask : wait_flag
   always #5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      timer_ovf <= (cyc % 4 == 3);
      if (cyc == 12000) begin
         n_fail++;
         wrap_up();
      end
   end
   always @(posedge sys_clk) begin : mon
      logic [15:0] e;
      rd_seen <= bus_req.rd;
      if (rd_seen) begin
         last_rd <= rdata;
         e = exp_rd.pop_front();
         if (e[15:8] != 8'h00) chk((rdata & e[15:8]) === e[7:0], "read value");
      end
      if (got) chk(got_frame === exp_tx.pop_front(), "frame on txd");
   end
   initial begin
      void'($urandom(37));
      repeat (10) @(posedge sys_clk);
      rst_n <= 1'h1;
      rd_reg(ASM_ADDR_CONTROL, {8'hFF, ASM_CTL_RESET});
      rd_reg(ASM_ADDR_BUFFER, {8'hFF, ASM_BUF_RESET});
      rd_reg(2'h3, 16'hFF00);
      $display("test reset done");
      for (int k = 0; k < 2; k++) begin
         bc = k ? 128 : 64;
         b = 8'($urandom);
         bit_cyc <= 8'(bc);
         wr_reg(ASM_ADDR_CONTROL, k ? 8'h30 : 8'h10);
         send_byte <= b;
         send <= 1'h1;
         exp_tx.push_back({1'h1, b ^ 8'h5A, 1'h0});
         wr_reg(ASM_ADDR_BUFFER, b ^ 8'h5A);
         bus_req.addr <= ASM_ADDR_CONTROL;
         bus_req.rd <= 1'h1;
         exp_rd.push_back(16'h4040);
         @(posedge sys_clk);
         bus_req.rd <= 1'h0;
         send <= 1'h0;
         wait_flag(ASM_CTL_TX_DONE, t0);
         chk(t0 >= 9 * bc - 4 && t0 <= 10 * bc + 8, "done timing");
         wait_flag(ASM_CTL_RX_DONE, t0);
         rd_reg(ASM_ADDR_CONTROL, 16'h0707);
         rd_reg(ASM_ADDR_BUFFER, {8'hFF, b});
         repeat (bc) @(posedge sys_clk);
         $display("test duplex %0d done", k);
      end
      wr_reg(ASM_ADDR_CONTROL, 8'h00);
      send <= 1'h1;
      @(posedge sys_clk);
      send <= 1'h0;
      repeat (1450) @(posedge sys_clk);
      rd_reg(ASM_ADDR_CONTROL, 16'h8200);
      $display("test rx disabled done");
      wrap_up();
   end
endmodule : async_serial_mode_one_tb_top
